// >>> racpl_consts.vh
// constants for the remote adc configuration and serial port lock registers
// assumes a 16-bit register address presented by the serial port front end
`ifndef RACPL_CONSTS_VH
`define RACPL_CONSTS_VH
// ****************************************
// register addresses
// ****************************************
`define RACPL_ADDR_REMOTE_ADC_CONFIG 16'hE708
`define RACPL_ADDR_PORT_LOCK_CONFIG 16'hEA00
// ****************************************
// field positions and reset values
// ****************************************
`define RACPL_AUX_SEL_LSB 0
`define RACPL_AUX_SEL_MSB 3
`define RACPL_CLK_OFF_BIT 6
`define RACPL_SOFT_RST_BIT 7
`define RACPL_LOCK_BIT 0
`define RACPL_AUX_SEL_RESET 4'hF
`define RACPL_ADC_CFG_RD_MASK 8'hCF
`define RACPL_LOCK_RD_MASK 8'h01
// ****************************************
// port selection and remote clock divider
// ****************************************
`define RACPL_SS_TOGGLES 2'd3
`define RACPL_CLK_DIV_HALF 1'b1
`endif

// >>> racpl_top.v
// remote adc configuration register and host serial port lock register
// assumes a decoded write/read strobe from the serial front end and synchronous pin inputs
`include "racpl_consts.vh"

// Functional notes
// [R01] bits 0..3 select aux voltage input per remote adc; each resets to one
// [R02] cleared selection bit makes that adc measure its temperature sensor
// [R03] reserved bits reset to zero, read zero and control nothing
// [R04] bit 6 set holds remote clock output high; clear lets clock run
// [R05] writing one to bit 7 starts a software reset of all remote adcs
// [R06] while unlocked, three slave select toggles switch host port to spi
// [R07] with i2c chosen, writing lock bit one makes slave select toggles ignored
// [R08] with spi chosen, any write to port lock register locks the choice
// [R09] once locked, port choice changes only on hardware reset
module racpl_top (
	input wire CLOCK,
	input wire RST_B,
	input wire [15:0] ADDR,
	input wire [7:0] WDATA,
	input wire WR_STB,
	input wire RD_STB,
	input wire SLAVE_SELECT_PIN,
	output reg [7:0] RDATA,
	output reg RVALID,
	output reg PHASE_A_AUX_SELECT,
	output reg PHASE_B_AUX_SELECT,
	output reg PHASE_C_AUX_SELECT,
	output reg NEUTRAL_AUX_SELECT,
	output reg REMOTE_CLOCK_OUTPUT,
	output reg REMOTE_SOFT_RESET,
	output reg HOST_PORT_SPI,
	output reg HOST_PORT_LOCKED
);

	// ****************************************
	// registers and next values
	// ****************************************
	reg [3:0] aux_sel_r;
	reg [3:0] aux_sel_nxt;
	reg clk_off_r;
	reg clk_off_nxt;
	reg soft_rst_nxt;
	reg lock_bit_r;
	reg lock_bit_nxt;
	reg spi_sel_r;
	reg spi_sel_nxt;
	reg locked_r;
	reg locked_nxt;
	reg ss_prev_r;
	reg [1:0] toggle_cnt_r;
	reg [1:0] toggle_cnt_nxt;
	reg div_cnt_r;
	reg rclk_r;
	reg rclk_nxt;
	reg [7:0] rdata_nxt;
	wire wr_adc_cfg;
	wire wr_lock_cfg;
	wire rd_adc_cfg;
	wire rd_lock_cfg;
	wire ss_edge;

	// ****************************************
	// decode helpers
	// ****************************************
	// true when the strobe is high and the address matches exactly
	function addr_hit;
		input stb;
		input [15:0] a;
		input [15:0] target;
		begin
			addr_hit = stb && (a == target);
		end
	endfunction

	// readable image of the adc configuration, reserved bits forced low
	function [7:0] adc_cfg_image;
		input [3:0] sel;
		input off;
		begin
			adc_cfg_image = {1'b0, off, 2'b00, sel} & `RACPL_ADC_CFG_RD_MASK;
		end
	endfunction

	assign wr_adc_cfg = addr_hit(WR_STB, ADDR, `RACPL_ADDR_REMOTE_ADC_CONFIG);
	assign wr_lock_cfg = addr_hit(WR_STB, ADDR, `RACPL_ADDR_PORT_LOCK_CONFIG);
	assign rd_adc_cfg = addr_hit(RD_STB, ADDR, `RACPL_ADDR_REMOTE_ADC_CONFIG);
	assign rd_lock_cfg = addr_hit(RD_STB, ADDR, `RACPL_ADDR_PORT_LOCK_CONFIG);
	assign ss_edge = (SLAVE_SELECT_PIN != ss_prev_r);

	// ****************************************
	// remote adc configuration
	// ****************************************
	always @* begin
		aux_sel_nxt = aux_sel_r;
		clk_off_nxt = clk_off_r;
		soft_rst_nxt = 1'b0;
		if (wr_adc_cfg) begin
			aux_sel_nxt = WDATA[`RACPL_AUX_SEL_MSB:`RACPL_AUX_SEL_LSB]; // [R01] [R02]
			clk_off_nxt = WDATA[`RACPL_CLK_OFF_BIT]; // [R04]
			// one-cycle pulse, the bit self-clears and reads back zero
			soft_rst_nxt = WDATA[`RACPL_SOFT_RST_BIT]; // [R05]
		end
	end

	always @(posedge CLOCK) begin
		if (!RST_B) begin
			aux_sel_r <= `RACPL_AUX_SEL_RESET; // [R01]
			clk_off_r <= 1'b0; // [R04]
			REMOTE_SOFT_RESET <= 1'b0; // [R05]
		end else begin
			aux_sel_r <= aux_sel_nxt;
			clk_off_r <= clk_off_nxt;
			REMOTE_SOFT_RESET <= soft_rst_nxt; // [R05]
		end
	end

	always @(posedge CLOCK) begin
		if (!RST_B) begin
			PHASE_A_AUX_SELECT <= 1'b1;
			PHASE_B_AUX_SELECT <= 1'b1;
			PHASE_C_AUX_SELECT <= 1'b1;
			NEUTRAL_AUX_SELECT <= 1'b1;
		end else begin
			PHASE_A_AUX_SELECT <= aux_sel_r[0]; // [R01] [R02]
			PHASE_B_AUX_SELECT <= aux_sel_r[1]; // [R01] [R02]
			PHASE_C_AUX_SELECT <= aux_sel_r[2]; // [R01] [R02]
			NEUTRAL_AUX_SELECT <= aux_sel_r[3]; // [R01] [R02]
		end
	end

	// ****************************************
	// remote clock output, clock divided by four
	// ****************************************
	// divider flips every cycle, square wave flips every other cycle
	always @* begin
		rclk_nxt = rclk_r;
		if (div_cnt_r == `RACPL_CLK_DIV_HALF) begin
			rclk_nxt = ~rclk_r;
		end
	end

	always @(posedge CLOCK) begin
		if (!RST_B) begin
			div_cnt_r <= 1'b0;
			rclk_r <= 1'b0;
			REMOTE_CLOCK_OUTPUT <= 1'b0;
		end else begin
			div_cnt_r <= ~div_cnt_r;
			rclk_r <= rclk_nxt;
			// held high while disabled so the remote side sees no edges
			REMOTE_CLOCK_OUTPUT <= clk_off_r | rclk_r; // [R04]
		end
	end

	// ****************************************
	// host port selection and lock
	// ****************************************
	always @* begin
		toggle_cnt_nxt = toggle_cnt_r;
		spi_sel_nxt = spi_sel_r;
		// toggles are ignored once locked or once spi is chosen
		if (!locked_r && !spi_sel_r && ss_edge) begin
			if (toggle_cnt_r == `RACPL_SS_TOGGLES - 2'd1) begin
				spi_sel_nxt = 1'b1; // [R06]
			end else begin
				toggle_cnt_nxt = toggle_cnt_r + 2'd1; // [R06] [R07]
			end
		end
	end

	always @* begin
		lock_bit_nxt = lock_bit_r;
		locked_nxt = locked_r;
		if (wr_lock_cfg) begin
			// sticky until reset, reads back one once a one was written
			lock_bit_nxt = lock_bit_r | WDATA[`RACPL_LOCK_BIT]; // [R07]
			if (spi_sel_r || WDATA[`RACPL_LOCK_BIT]) begin
				locked_nxt = 1'b1; // [R07] [R08] [R09]
			end
		end
	end

	always @(posedge CLOCK) begin
		if (!RST_B) begin
			ss_prev_r <= 1'b1;
			toggle_cnt_r <= 2'd0;
			spi_sel_r <= 1'b0;
			locked_r <= 1'b0; // [R09]
			lock_bit_r <= 1'b0; // [R07]
		end else begin
			ss_prev_r <= SLAVE_SELECT_PIN;
			toggle_cnt_r <= toggle_cnt_nxt;
			spi_sel_r <= spi_sel_nxt;
			locked_r <= locked_nxt;
			lock_bit_r <= lock_bit_nxt;
		end
	end

	// ****************************************
	// read data and status outputs
	// ****************************************
	always @* begin
		rdata_nxt = RDATA;
		if (rd_adc_cfg) begin
			rdata_nxt = adc_cfg_image(aux_sel_r, clk_off_r); // [R03]
		end else if (rd_lock_cfg) begin
			rdata_nxt = {7'h00, lock_bit_r} & `RACPL_LOCK_RD_MASK; // [R03]
		end else if (RD_STB) begin
			// unmapped addresses read as zero
			rdata_nxt = 8'h00;
		end
	end

	always @(posedge CLOCK) begin
		if (!RST_B) begin
			HOST_PORT_SPI <= 1'b0;
			HOST_PORT_LOCKED <= 1'b0;
			RDATA <= 8'h00;
			RVALID <= 1'b0;
		end else begin
			HOST_PORT_SPI <= spi_sel_r;
			HOST_PORT_LOCKED <= locked_r;
			RDATA <= rdata_nxt;
			RVALID <= RD_STB;
		end
	end

endmodule // racpl_top

// >>> racpl_chk_properties.sv
// assertions on the racpl_top ports
// assumes the bind at the foot of this file
module racpl_chk(
	input wire CLOCK,
	input wire RST_B,
	input wire WR_STB,
	input wire RD_STB,
	input wire RVALID,
	input wire PHASE_A_AUX_SELECT,
	input wire PHASE_B_AUX_SELECT,
	input wire PHASE_C_AUX_SELECT,
	input wire NEUTRAL_AUX_SELECT,
	input wire REMOTE_CLOCK_OUTPUT,
	input wire REMOTE_SOFT_RESET,
	input wire HOST_PORT_SPI,
	input wire HOST_PORT_LOCKED,
	input wire [15:0] ADDR,
	input wire [7:0] WDATA,
	input wire [7:0] RDATA
);
	wire [3:0] aux = {NEUTRAL_AUX_SELECT, PHASE_C_AUX_SELECT, PHASE_B_AUX_SELECT,
		PHASE_A_AUX_SELECT};
	wire wc = WR_STB && ADDR == 16'hE708;
	wire wl = WR_STB && ADDR == 16'hEA00;
	wire ws = wc && WDATA[7];
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	a_srst_go: assert property (ws |=> REMOTE_SOFT_RESET) else $error("rst");
	a_srst_why: assert property (REMOTE_SOFT_RESET |-> $past(ws)) else $error("rst");
	a_clk_held: assert property (wc && WDATA[6] |-> ##2 REMOTE_CLOCK_OUTPUT [*4])
		else $error("clk");
	a_rd_resv: assert property (RD_STB && ADDR == 16'hE708 |=> (RDATA & 8'hB0) == 0)
		else $error("rd");
	a_lock_i2c: assert property (wl && WDATA[0] |-> ##2 HOST_PORT_LOCKED) else $error("lk");
	a_lock_spi: assert property (wl && HOST_PORT_SPI |-> ##2 HOST_PORT_LOCKED)
		else $error("lk");
	a_lock_stay: assert property (HOST_PORT_LOCKED |=> HOST_PORT_LOCKED) else $error("lk");
	a_port_hold: assert property (HOST_PORT_LOCKED |=> $stable(HOST_PORT_SPI))
		else $error("sp");
	a_aux_follow: assert property (wc |-> ##2 aux == $past(WDATA[3:0], 2))
		else $error("aux");
	a_rd_pulse: assert property (RD_STB |=> RVALID) else $error("rv");
	cover property (REMOTE_SOFT_RESET);
	cover property (REMOTE_CLOCK_OUTPUT ##1 !REMOTE_CLOCK_OUTPUT);
	cover property (HOST_PORT_SPI && HOST_PORT_LOCKED);
	cover property (HOST_PORT_LOCKED && !HOST_PORT_SPI);
endmodule // racpl_chk
bind racpl_top racpl_chk racpl_chk_i(.*);

// >>> racpl_host.sv
// host model driving register strobes and slave select
// assumes the bench clock; changes land 1 ns after an edge
module racpl_host(
	input wire CLOCK,
	output logic [15:0] ADDR,
	output logic [7:0] WDATA,
	output logic WR_STB,
	output logic RD_STB,
	output logic SLAVE_SELECT_PIN
);
	timeunit 1ns / 1ps;
	initial {ADDR, WDATA, WR_STB, RD_STB, SLAVE_SELECT_PIN} = 27'h000_0001;
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge CLOCK) #1 {ADDR, WDATA, WR_STB, RD_STB} = {a, d, w, !w};
		@(posedge CLOCK) #1 {ADDR, WDATA, WR_STB, RD_STB} = {~a, ~d, 2'b00};
	endtask
	task tog(input int n);
		repeat (n) @(posedge CLOCK) #1 SLAVE_SELECT_PIN = !SLAVE_SELECT_PIN;
		#30;
	endtask
endmodule // racpl_host

// >>> tb.sv
// bench for racpl_top through the host model
// assumes racpl_chk is bound from its own file
module tb;
	timeunit 1ns / 1ps;
	logic CLOCK = 0, RST_B = 0;
	int n_fail = 0, compares = 0;
	wire [15:0] ADDR;
	wire [7:0] WDATA, RDATA;
	wire WR_STB, RD_STB, SLAVE_SELECT_PIN, RVALID, PHASE_A_AUX_SELECT, PHASE_B_AUX_SELECT;
	wire PHASE_C_AUX_SELECT, NEUTRAL_AUX_SELECT, REMOTE_CLOCK_OUTPUT, REMOTE_SOFT_RESET;
	wire HOST_PORT_SPI, HOST_PORT_LOCKED;
	wire [3:0] aux_pins;
	assign aux_pins = {NEUTRAL_AUX_SELECT, PHASE_C_AUX_SELECT, PHASE_B_AUX_SELECT,
		PHASE_A_AUX_SELECT};
	always #5 CLOCK = ~CLOCK;
	racpl_host racpl_host_i(.*);
	racpl_top racpl_top_i(.*);
	task chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask
	task rdc(input logic [15:0] a, input logic [7:0] e);
		racpl_host_i.acc(0, a, 8'h00);
		chk(RDATA, e);
		chk(RVALID, 8'h01);
		@(posedge CLOCK) #1;
		chk(RVALID, 8'h00);
		chk(RDATA, e);
	endtask
	task t_clk(input int ones);
		int k;
		k = 0;
		repeat (8) begin
			@(posedge CLOCK) #1;
			k += REMOTE_CLOCK_OUTPUT;
		end
		chk(8'(k), 8'(ones));
	endtask
	task wrap_up;
		if (n_fail == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task t_adc;
		rdc(16'hE708, 8'h0F);
		chk(aux_pins, 8'h0F);
		for (int i = 0; i < 4; i++) begin
			racpl_host_i.acc(1, 16'hE708, 8'h0F ^ (8'h01 << i));
			rdc(16'hE708, 8'h0F ^ (8'h01 << i));
			chk(aux_pins, 8'h0F ^ (8'h01 << i));
		end
		t_clk(4);
		rdc(16'h0000, 8'h00);
		racpl_host_i.acc(1, 16'hE708, 8'hFF);
		chk(REMOTE_SOFT_RESET, 8'h01);
		@(posedge CLOCK) #1;
		chk(REMOTE_SOFT_RESET, 8'h00);
		t_clk(8);
		rdc(16'hE708, 8'h4F);
		chk(aux_pins, 8'h0F);
		racpl_host_i.acc(1, 16'hE708, 8'h0F);
		t_clk(4);
	endtask
	task t_port;
		racpl_host_i.tog(2);
		chk(HOST_PORT_SPI, 8'h00);
		racpl_host_i.tog(1);
		chk(HOST_PORT_SPI, 8'h01);
		racpl_host_i.acc(1, 16'hEA00, 8'h00);
		rdc(16'hEA00, 8'h00);
		chk(HOST_PORT_LOCKED, 8'h01);
		racpl_host_i.tog(3);
		chk(HOST_PORT_SPI, 8'h01);
		@(posedge CLOCK) #1 RST_B = 0;
		repeat (2) @(posedge CLOCK);
		#1 RST_B = 1;
		chk({HOST_PORT_LOCKED, HOST_PORT_SPI}, 8'h00);
		chk(aux_pins, 8'h0F);
		racpl_host_i.acc(1, 16'hEA00, 8'hFF);
		racpl_host_i.tog(3);
		chk({HOST_PORT_LOCKED, HOST_PORT_SPI}, 8'h02);
		rdc(16'hEA00, 8'h01);
	endtask
	initial begin
		repeat (12) @(posedge CLOCK);
		#1 RST_B = 1;
		t_adc;
		t_port;
		wrap_up;
	end
endmodule // tb
